// ---- rtl/windowed_watchdog_timer.v ----
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "wdog_defs.vh"
// Contract
// - 12-bit down counter loaded from reload value
// - decrement every 128 slow clock ticks
// - reset reload 0xFFF, fault reset enabled
// - processor reset restores initial values, unlocks setup
// - setup register accepts only first write
// - accepted setup write reloads and restarts counter
// - keyed kick reloads counter, restarts prescaler
// - command write without key does nothing
// - underflow sets flag, fault if enabled
// - early kick sets error flag and fault
// - window limit >= reload disables window check
// - flags raise interrupt only when enabled
// - watchdog reset clears both flags
// - flags read clears flags, interrupt, fault
// - counter pauses in debug or idle if halted
// - kick needs key 0xA5 in top byte
// - core-only select picks processor or all resets
// - halt bit one stops, zero keeps running
module windowed_watchdog_timer (
  // clock, reset, enable
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire        CE,
  // slow clock and processor state (asynchronous pins)
  input  wire        SLOW_CLK,
  input  wire        DEBUG_STATE,
  input  wire        IDLE_STATE,
  // register port
  input  wire [3:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  // towards interrupt and reset controllers
  output reg         IRQ,
  output reg         FAULT,
  output reg         FAULT_CORE_ONLY,
  output reg  [11:0] COUNT
);

  reg  [1:0]  slow_sync_q;
  reg  [1:0]  dbg_sync_q;
  reg  [1:0]  idle_sync_q;
  reg         slow_prev_q;
  reg  [`PRESCALE_W-1:0] prescale_q;
  reg  [`PRESCALE_W-1:0] prescale_d;
  reg  [31:0] setup_q;
  reg  [31:0] setup_d;
  reg         locked_q;
  reg         locked_d;
  reg  [11:0] count_q;
  reg  [11:0] count_d;
  reg         unf_q;
  reg         unf_d;
  reg         err_q;
  reg         err_d;
  reg         fault_d;
  reg  [31:0] rdata_d;
  wire        slow_rise;
  wire        wr_setup;
  wire        kick;
  wire        halted;
  wire        tick;
  wire        early;

  // ignores don't-care bits so reads show only implemented fields
  function [31:0] flags_word;
    input u;
    input e;
    begin
      flags_word = 32'h0000_0000;
      flags_word[`UNDERFLOW_FLAG]  = u;
      flags_word[`WINDOW_ERR_FLAG] = e;
    end
  endfunction

  assign slow_rise = slow_sync_q[1] & ~slow_prev_q;
  assign wr_setup  = WR & (ADDR == `OFS_SETUP) & ~locked_q;
  assign kick      = WR & (ADDR == `OFS_COMMAND) & WDATA[`KICK_BIT] &
                     (WDATA[`KEY_MSB:`KEY_LSB] == `UNLOCK_KEY_VALUE);
  // a halt bit of one stops the counter in that state
  assign halted    = (setup_q[`DEBUG_HALT] & dbg_sync_q[1]) |
                     (setup_q[`IDLE_HALT] & idle_sync_q[1]);
  assign tick      = slow_rise & (prescale_q == {`PRESCALE_W{1'b1}}) &
                     ~setup_q[`TIMER_OFF] & ~halted;
  // the check runs even with the timer off; limit >= reload never fails
  assign early     = count_q > setup_q[`WINDOW_MSB:`WINDOW_LSB];

  always @* begin
    prescale_d = prescale_q;
    setup_d    = setup_q;
    locked_d   = locked_q;
    count_d    = count_q;
    unf_d      = unf_q;
    err_d      = err_q;
    fault_d    = FAULT;
    rdata_d    = 32'h0000_0000;
    // reading the flags clears them; a same-cycle event still wins below
    if (RD && ADDR == `OFS_FLAGS) begin
      rdata_d = flags_word(unf_q, err_q);
      unf_d   = 1'b0;
      err_d   = 1'b0;
      fault_d = 1'b0;
    end else if (RD && ADDR == `OFS_SETUP) begin
      rdata_d = setup_q;
    end
    if (slow_rise)
      prescale_d = prescale_q + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
    if (tick) begin
      if (count_q == 12'h000) begin
        unf_d = 1'b1;
        if (setup_q[`FAULT_RST_EN])
          fault_d = 1'b1;
        count_d = setup_q[`RELOAD_MSB:`RELOAD_LSB];
      end else begin
        count_d = count_q - 12'h001;
      end
    end
    if (wr_setup) begin
      setup_d    = WDATA & `SETUP_MASK;
      locked_d   = 1'b1;
      count_d    = WDATA[`RELOAD_MSB:`RELOAD_LSB];
      prescale_d = {`PRESCALE_W{1'b0}};
    end else if (kick) begin
      if (early) begin
        err_d   = 1'b1;
        fault_d = 1'b1;
      end else begin
        count_d    = setup_q[`RELOAD_MSB:`RELOAD_LSB];
        prescale_d = {`PRESCALE_W{1'b0}};
      end
    end
  end

  // NRST is the processor/watchdog reset: restores defaults and unlocks
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      slow_sync_q <= 2'b00;
      dbg_sync_q  <= 2'b00;
      idle_sync_q <= 2'b00;
      slow_prev_q <= 1'b0;
      prescale_q  <= {`PRESCALE_W{1'b0}};
      setup_q     <= `SETUP_RESET;
      locked_q    <= 1'b0;
      count_q     <= 12'hFFF;
      unf_q       <= 1'b0;
      err_q       <= 1'b0;
      FAULT       <= 1'b0;
      FAULT_CORE_ONLY <= 1'b0;
      IRQ         <= 1'b0;
      RDATA       <= 32'h0000_0000;
      COUNT       <= 12'hFFF;
    end else if (CE) begin
      slow_sync_q <= {slow_sync_q[0], SLOW_CLK};
      dbg_sync_q  <= {dbg_sync_q[0], DEBUG_STATE};
      idle_sync_q <= {idle_sync_q[0], IDLE_STATE};
      slow_prev_q <= slow_sync_q[1];
      prescale_q  <= prescale_d;
      setup_q     <= setup_d;
      locked_q    <= locked_d;
      count_q     <= count_d;
      unf_q       <= unf_d;
      err_q       <= err_d;
      FAULT       <= fault_d;
      FAULT_CORE_ONLY <= setup_d[`CORE_ONLY_SEL];
      IRQ         <= setup_d[`FAULT_IRQ_EN] & (unf_d | err_d);
      RDATA       <= rdata_d;
      COUNT       <= count_d;
    end
  end

endmodule // windowed_watchdog_timer

// ---- rtl/wdog_defs.vh ----
`ifndef WDOG_DEFS_VH
`define WDOG_DEFS_VH
// register offsets
`define OFS_COMMAND      4'h0
`define OFS_SETUP        4'h4
`define OFS_FLAGS        4'h8
// command register fields
`define KEY_MSB          31
`define KEY_LSB          24
`define UNLOCK_KEY_VALUE 8'hA5
`define KICK_BIT         0
// setup register fields and reset value
`define SETUP_RESET      32'h3FFF_2FFF
`define RELOAD_MSB       11
`define RELOAD_LSB       0
`define FAULT_IRQ_EN     12
`define FAULT_RST_EN     13
`define CORE_ONLY_SEL    14
`define TIMER_OFF        15
`define WINDOW_MSB       27
`define WINDOW_LSB       16
`define DEBUG_HALT       28
`define IDLE_HALT        29
`define SETUP_MASK       32'h3FFF_FFFF
// flags register fields
`define UNDERFLOW_FLAG   0
`define WINDOW_ERR_FLAG  1
// timing
`define SLOW_DIV         128
`define PRESCALE_W       7
`endif

// ---- testbench/wd_chk_assertions.sv ----
`timescale 1ns/1ns
module wd_chk (
  input wire        CLOCK, NRST, CE, WR, RD, IRQ, FAULT, FAULT_CORE_ONLY,
  input wire [3:0]  ADDR,
  input wire [31:0] WDATA, RDATA,
  input wire [11:0] COUNT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // shadow of the write-once setup register
  reg  [29:0] cfg_q;
  reg         lock_q;
  wire        go = CE && WR;
  wire        rf = CE && RD && ADDR == 4'h8;
  wire        ie = cfg_q[12];
  wire        co = cfg_q[14];
  always @(posedge CLOCK or negedge NRST)
    if (!NRST) begin
      cfg_q <= 30'h3FFF_2FFF;
      lock_q <= 1'b0;
    end else if (go && ADDR == 4'h4 && !lock_q) begin
      cfg_q <= WDATA[29:0];
      lock_q <= 1'b1;
    end
  sequence s_kick;
    go && ADDR == 4'h0 && WDATA[31:24] == 8'hA5 && WDATA[0];
  endsequence
  property p_ok; s_kick ##0 COUNT <= cfg_q[27:16] |=> COUNT == cfg_q[11:0];
  endproperty
  a_ok: assert property (p_ok) else $error("kick reload");
  property p_early; s_kick ##0 COUNT > cfg_q[27:16] |=> FAULT; endproperty
  a_early: assert property (p_early) else $error("early kick");
  property p_set; go && ADDR == 4'h4 && !lock_q |=> COUNT == cfg_q[11:0];
  endproperty
  a_set: assert property (p_set) else $error("setup reload");
  property p_key; go && ADDR == 4'h0 && WDATA[31:24] != 8'hA5 &&
    COUNT != 12'h000 && !FAULT |=> !FAULT; endproperty
  a_key: assert property (p_key) else $error("bad key");
  property p_rd; CE && RD && ADDR == 4'h4 |=> RDATA == {2'b00, $past(cfg_q)};
  endproperty
  a_rd: assert property (p_rd) else $error("setup read");
  property p_clr; rf && COUNT != 12'h000 |=> !FAULT && !IRQ; endproperty
  a_clr: assert property (p_clr) else $error("flag clear");
  property p_irq; IRQ |-> ie; endproperty
  a_irq: assert property (p_irq) else $error("irq enable");
  property p_hold; FAULT && !rf |=> FAULT; endproperty
  a_hold: assert property (p_hold) else $error("fault hold");
  property p_core; FAULT_CORE_ONLY == co; endproperty
  a_core: assert property (p_core) else $error("core only");
endmodule // wd_chk
bind windowed_watchdog_timer wd_chk wd_chk_i (.CLOCK, .NRST, .CE, .WR, .RD,
  .IRQ, .FAULT, .FAULT_CORE_ONLY, .ADDR, .WDATA, .RDATA, .COUNT);

// ---- testbench/slow_src.sv ----
`timescale 1ns/1ns
module slow_src (output logic SLOW_CLK);
  // far faster than real so a prescaled tick is 1024 fast cycles
  initial SLOW_CLK = 1'b0;
  always #80 SLOW_CLK = ~SLOW_CLK;
endmodule // slow_src

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
  logic        clock = 1'b0, nrst = 1'b0, dbg = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        irq, fault, core, slow;
  logic [11:0] count;
  int          n_mismatch = 0, num_checks = 0;
  always #10 clock = ~clock;
  slow_src slow_src_i (.SLOW_CLK(slow));
  windowed_watchdog_timer windowed_watchdog_timer_i (.CLOCK(clock),
    .NRST(nrst), .CE(1'b1), .SLOW_CLK(slow), .DEBUG_STATE(dbg),
    .IDLE_STATE(1'b0), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .FAULT(fault), .FAULT_CORE_ONLY(core),
    .COUNT(count));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                        input string n);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  // uf high waits for a fault, low for the restart window
  task automatic wait_until(input logic uf);
    for (int i = 0; i < 30000; i++) begin
      @(posedge clock);
      #1;
      if (uf ? fault === 1'b1 : count <= 12'h004) return;
    end
    n_mismatch++;
    close_out();
  endtask
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_reg(4'h4, 32'h3FFF_2FFF, "setup");
    wr_reg(4'h0, 32'h5A00_0001);
    wr_reg(4'h0, 32'hA500_0001);
    rd_reg(4'h8, 32'h0000_0000, "flags");
    repeat (30) @(posedge clock);
    wr_reg(4'h4, 32'h1004_7010);
    `CHK("count", 12'h010, count)
    wr_reg(4'h4, 32'h0000_0FFF);
    rd_reg(4'h4, 32'h1004_7010, "setup");
    wr_reg(4'h0, 32'hA500_0001);
    `CHK("fault", 3'b111, {fault, irq, core})
    rd_reg(4'h8, 32'h0000_0002, "flags");
    `CHK("clear", 2'b00, {fault, irq})
    dbg <= 1'b1;
    repeat (3000) @(posedge clock);
    #1;
    `CHK("halt", 12'h010, count)
    dbg <= 1'b0;
    wait_until(1'b0);
    wr_reg(4'h0, 32'h5A00_0001);
    `CHK("nokey", 12'h004, count)
    wr_reg(4'h0, 32'hA500_0001);
    `CHK("kick", 12'h010, count)
    wait_until(1'b1);
    rd_reg(4'h8, 32'h0000_0001, "flags");
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    rd_reg(4'h4, 32'h3FFF_2FFF, "setup");
    close_out();
  end
endmodule // tb
